/* rtl/eep_master.sv */
`timescale 1ns/1ps
// Write data FIFO between the user and the serial engine
module eep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] cnt_reg;
  logic [PW:0] cnt_next;  // Fill level after this edge
  logic room_reg;         // Not-full flag kept in a flop so in_ready leaves a register

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign in_ready = room_reg;
  assign out_valid = (cnt_reg != '0);
  assign out_data = store[rptr_reg];

  // Pointers wrap on the power of two depth
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      room_reg <= 1'b1;
    end else begin
      wptr_reg <= wptr_reg + PW'(push);
      rptr_reg <= rptr_reg + PW'(pop);
      cnt_reg <= cnt_next;
      room_reg <= (cnt_next != (PW+1)'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wptr_reg] <= in_data;
    end
  end
endmodule : eep_fifo

// Bus master end: runs one write or selective read per command
module eep_master #(
  parameter int QTR = eep_pkg::SCL_QTR
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Two-wire link
  eep_bus_if.master bus,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_dev,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  output logic cmd_ready,
  // Write data stream
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Read data and status
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack
);

  // ************************************************************
  // Data line synchroniser and clock divider
  // ************************************************************
  logic sda1_reg;
  logic sda2_reg;
  logic [7:0] div_reg;
  wire tick = (div_reg == 8'(QTR - 1));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sda1_reg <= 1'b1;
      sda2_reg <= 1'b1;
      div_reg <= 8'h00;
    end else begin
      sda1_reg <= bus.sda;
      sda2_reg <= sda1_reg;
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // ************************************************************
  // Sequencer state
  // ************************************************************
  eep_pkg::eep_mst_state_t st_reg;
  eep_pkg::eep_mst_step_t step_reg;
  logic [1:0] qph_reg;      // Quarter of the current bit
  logic [3:0] bit_reg;      // Bit of the current byte
  logic [7:0] shift_reg;
  logic scl_reg;
  logic oe_reg;
  logic rd_reg;
  logic [2:0] dev_reg;
  logic [15:0] addr_reg;
  logic [7:0] len_reg;
  logic ready_reg;
  logic [7:0] rdat_reg;
  logic rval_reg;
  logic done_reg;
  logic nack_reg;
  logic [7:0] fifo_data;
  logic fifo_valid;

  wire need_data = (step_reg == eep_pkg::MP_DATA);
  wire load = tick & (st_reg == eep_pkg::MS_BYTE) & (bit_reg == 4'h0) & (qph_reg == 2'h0);
  wire stall = need_data & ~fifo_valid;  // Hold SCL high until data arrives
  wire pop = load & need_data & fifo_valid;
  wire byte_done = tick & (st_reg == eep_pkg::MS_BYTE) & (qph_reg == 2'h3) & (bit_reg == 4'h8);
  wire got_ack = ~sda2_reg;
  wire [7:0] tx_byte = (step_reg == eep_pkg::MP_DEVW) ? {eep_pkg::DEV_TYPE, dev_reg, eep_pkg::RW_WRITE} :
                       (step_reg == eep_pkg::MP_DEVR) ? {eep_pkg::DEV_TYPE, dev_reg, eep_pkg::RW_READ} :
                       (step_reg == eep_pkg::MP_AHI) ? addr_reg[15:8] :
                       (step_reg == eep_pkg::MP_ALO) ? addr_reg[7:0] :
                       need_data ? fifo_data : 8'hFF;

  eep_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pop)
  );

  // ************************************************************
  // Bit and byte sequencing
  // ************************************************************
  // Quarter 0 lowers SCL and lets go of SDA, 1 sets SDA, 2 raises SCL,
  // 3 samples; the gap keeps us off a slave that still holds the line
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg <= eep_pkg::MS_IDLE;
      step_reg <= eep_pkg::MP_DEVW;
      qph_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      dev_reg <= 3'h0;
      addr_reg <= 16'h0000;
      len_reg <= 8'h00;
      ready_reg <= 1'b1;
      rdat_reg <= 8'h00;
      rval_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      rval_reg <= 1'b0;
      done_reg <= 1'b0;
      if (st_reg == eep_pkg::MS_IDLE) begin
        // Bus is released here, so a new START is legal
        if (cmd_valid) begin
          st_reg <= eep_pkg::MS_START;
          step_reg <= eep_pkg::MP_DEVW;
          rd_reg <= cmd_read;
          dev_reg <= cmd_dev;
          addr_reg <= cmd_addr;
          len_reg <= cmd_len;
          ready_reg <= 1'b0;
          nack_reg <= 1'b0;
          qph_reg <= 2'h0;
        end
      end else if (tick && !(load && stall)) begin
        qph_reg <= qph_reg + 2'h1;
        unique case (st_reg)
          eep_pkg::MS_START: begin
            // Same shape serves first and repeated START
            if (qph_reg == 2'h0) scl_reg <= 1'b0;
            if (qph_reg == 2'h1) oe_reg <= 1'b0;
            if (qph_reg == 2'h2) scl_reg <= 1'b1;
            if (qph_reg == 2'h3) begin
              oe_reg <= 1'b1;
              st_reg <= eep_pkg::MS_BYTE;
              bit_reg <= 4'h0;
            end
          end
          eep_pkg::MS_STOP: begin
            if (qph_reg == 2'h0) scl_reg <= 1'b0;
            if (qph_reg == 2'h1) oe_reg <= 1'b1;
            if (qph_reg == 2'h2) scl_reg <= 1'b1;
            if (qph_reg == 2'h3) begin
              oe_reg <= 1'b0;
              st_reg <= eep_pkg::MS_IDLE;
              ready_reg <= 1'b1;
              done_reg <= 1'b1;
            end
          end
          default: begin
            if (qph_reg == 2'h0) begin
              // Release with the fall; the slave answers a few clocks later
              scl_reg <= 1'b0;
              oe_reg <= 1'b0;
              if (bit_reg == 4'h0) begin
                shift_reg <= tx_byte;
              end
            end
            if (qph_reg == 2'h1) begin
              if (bit_reg == 4'h8) begin
                // ACK each read byte but the last
                oe_reg <= (step_reg == eep_pkg::MP_RD) && (len_reg != 8'h01);
              end else begin
                oe_reg <= ~shift_reg[7];
              end
            end
            if (qph_reg == 2'h2) scl_reg <= 1'b1;
            if (qph_reg == 2'h3 && bit_reg != 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda2_reg};
              bit_reg <= bit_reg + 4'h1;
            end
            if (byte_done) begin
              bit_reg <= 4'h0;
              st_reg <= eep_pkg::MS_BYTE;
              unique case (step_reg)
                eep_pkg::MP_RD: begin
                  rdat_reg <= shift_reg;
                  rval_reg <= 1'b1;
                  len_reg <= len_reg - 8'h01;
                  if (len_reg == 8'h01) st_reg <= eep_pkg::MS_STOP;
                end
                default: begin
                  if (!got_ack) begin
                    // Missing ACK: busy device or wrong address
                    nack_reg <= 1'b1;
                    st_reg <= eep_pkg::MS_STOP;
                  end else if (step_reg == eep_pkg::MP_DEVW) begin
                    step_reg <= eep_pkg::MP_AHI;
                  end else if (step_reg == eep_pkg::MP_AHI) begin
                    step_reg <= eep_pkg::MP_ALO;
                  end else if (step_reg == eep_pkg::MP_DEVR) begin
                    step_reg <= eep_pkg::MP_RD;
                  end else if (len_reg == 8'h00 || (need_data && len_reg == 8'h01)) begin
                    st_reg <= eep_pkg::MS_STOP;
                  end else if (rd_reg) begin
                    step_reg <= eep_pkg::MP_DEVR;
                    st_reg <= eep_pkg::MS_START;
                  end else begin
                    if (need_data) len_reg <= len_reg - 8'h01;
                    step_reg <= eep_pkg::MP_DATA;
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus.scl = scl_reg;
  assign bus.master_sda_oe = oe_reg;
  assign cmd_ready = ready_reg;
  assign rd_data = rdat_reg;
  assign rd_valid = rval_reg;
  assign done = done_reg;
  assign nack = nack_reg;

endmodule : eep_master

/* shared/eep_pkg.sv */
package eep_pkg;

  // ************************************************************
  // Memory organisation
  // ************************************************************
  localparam int MEM_BYTES = 8192;      // Whole array
  localparam int PAGE_BYTES = 64;       // Write buffer size
  localparam int MEM_AW = 13;           // Byte address width
  localparam int PAGE_AW = 6;           // Byte within page
  localparam int AHI_USED_MSB = 4;      // Highest upper address byte bit kept

  // ************************************************************
  // Slave address layout
  // ************************************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;  // Fixed upper nibble 1010
  localparam logic RW_READ = 1'h1;         // Direction bit for read
  localparam logic RW_WRITE = 1'h0;        // Direction bit for write
  localparam logic [3:0] ACK_BIT = 4'h8;   // Bit count at the ninth clock

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;       // ref_clk period
  localparam int WR_TIME_NS = 5000000;     // Longest internal write time
  localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;  // Rounds down
  localparam int SCL_QTR = 4;              // Master ticks per quarter bit

  // ************************************************************
  // State encodings
  // ************************************************************
  typedef enum logic [2:0] {SL_IDLE, SL_DEV, SL_AHI, SL_ALO, SL_WDATA, SL_RDATA} eep_slv_state_t;
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} eep_mst_state_t;
  typedef enum logic [2:0] {MP_DEVW, MP_AHI, MP_ALO, MP_DATA, MP_DEVR, MP_RD} eep_mst_step_t;

endpackage : eep_pkg

/* shared/eep_bus_if.sv */
`timescale 1ns/1ps
interface eep_bus_if;
  // Serial clock, driven only by the master
  logic scl;
  // Open-drain data line: each end pulls low while its enable is high
  logic master_sda_oe;
  logic slave_sda_oe;
  logic sda;

  // Pull-up resolution of the shared data wire
  assign sda = ~(master_sda_oe | slave_sda_oe);

  modport slave (input scl, input sda, output slave_sda_oe);
  modport master (output scl, output master_sda_oe, input sda);
endinterface : eep_bus_if

/* rtl/eep_slave.sv */
`timescale 1ns/1ps
// Overview of operation
// - Pull SDA low for zero, release for one
// - SDA change while SCL high is START/STOP
// - START on SDA fall, ignore traffic before
// - STOP launches write cycle or idles
// - Address 1010 plus select pins, bit0 direction
// - ACK in ninth clock for written bytes
// - Read: eight bits, release, continue on ACK
// - Master ends read with NACK then STOP
// - Byte write: four acknowledged bytes then STOP
// - No address ACK during internal write
// - Drop top three bits, page and byte
// - Write pointer wraps inside the page
// - Master polls busy by missing ACK
// - Write-protect high blocks every memory change; code checks it only at STOP, so a write already launched still commits
// - Counter points past last byte, wraps
// - Read address ACKed, then counter byte sent
// - Selective read: dummy write, repeated START
// - Sequential read wraps at memory end
// - Master starts only on idle bus
// - Sample on SCL rise, drive after fall
// - Three select pins allow eight devices
module eep_slave #(
  parameter int WR_CYCLES = eep_pkg::WR_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Two-wire link
  eep_bus_if.slave bus,
  // Straps
  input wire logic bus_select_pin_zero,
  input wire logic bus_select_pin_one,
  input wire logic bus_select_pin_two,
  input wire logic write_protect,
  // Status
  output logic write_busy
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] scl_reg;   // [0] first stage, [1] synced, [2] previous
  logic [2:0] sda_reg;
  logic [3:0] pin1_reg;  // First stage of straps and protect
  logic [3:0] pin2_reg;  // Synced straps and protect

  // Two flops before use; third stage only for edge finding
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      scl_reg <= 3'h7;
      sda_reg <= 3'h7;
      pin1_reg <= 4'h0;
      pin2_reg <= 4'h0;
    end else begin
      scl_reg <= {scl_reg[1:0], bus.scl};
      sda_reg <= {sda_reg[1:0], bus.sda};
      pin1_reg <= {write_protect, bus_select_pin_two, bus_select_pin_one, bus_select_pin_zero};
      pin2_reg <= pin1_reg;
    end
  end

  // ************************************************************
  // Edge and condition decode
  // ************************************************************
  wire scl_rise = scl_reg[1] & ~scl_reg[2];
  wire scl_fall = ~scl_reg[1] & scl_reg[2];
  wire scl_hold = scl_reg[1] & scl_reg[2];
  wire start_det = scl_hold & sda_reg[2] & ~sda_reg[1];
  wire stop_det = scl_hold & ~sda_reg[2] & sda_reg[1];
  wire wp_on = pin2_reg[3];
  wire [2:0] sel_pins = pin2_reg[2:0];

  // ************************************************************
  // State
  // ************************************************************
  eep_pkg::eep_slv_state_t st_reg;  // Protocol phase
  logic [3:0] cnt_reg;              // Bits done in this byte
  logic ack_reg;                    // Inside the ninth clock
  logic [7:0] shift_reg;            // Receive or transmit byte
  logic oe_reg;                     // Pull SDA low
  logic nack_reg;                   // Master answer in read mode
  logic rw_reg;                     // Direction of this access
  logic [12:0] addr_reg;            // Internal address counter
  logic [63:0] valid_reg;           // Page buffer slots loaded
  logic busy_reg;                   // Internal write in progress
  logic [31:0] tmr_reg;             // Write cycle timer
  logic [6:0] cidx_reg;             // Commit index into page buffer
  logic [7:0] mem [0:eep_pkg::MEM_BYTES-1];
  logic [7:0] pbuf [0:eep_pkg::PAGE_BYTES-1];

  wire [7:0] rd_byte = mem[addr_reg];
  wire act = ~start_det & ~stop_det & (st_reg != eep_pkg::SL_IDLE);
  wire byte_end = act & scl_fall & ~ack_reg & (cnt_reg == eep_pkg::ACK_BIT);
  wire ack_end = act & scl_fall & ack_reg;
  wire dev_match = (shift_reg[7:4] == eep_pkg::DEV_TYPE) & (shift_reg[3:1] == sel_pins);
  // Only a STOP after at least one whole data byte writes; protect cancels
  wire launch = stop_det & (st_reg == eep_pkg::SL_WDATA) & (|valid_reg) & ~wp_on;
  wire buf_we = byte_end & (st_reg == eep_pkg::SL_WDATA);
  wire [5:0] widx = addr_reg[5:0];
  wire commit_we = busy_reg & ~cidx_reg[6] & valid_reg[cidx_reg[5:0]];

  // ************************************************************
  // Protocol engine
  // ************************************************************
  // START and STOP win over bit activity at any point of a byte
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_reg <= eep_pkg::SL_IDLE;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      shift_reg <= 8'h00;
      oe_reg <= 1'b0;
      nack_reg <= 1'b1;
      rw_reg <= 1'b0;
      addr_reg <= 13'h0000;
      valid_reg <= 64'h0;
    end else if (start_det) begin
      // Fresh command, also repeated START
      st_reg <= eep_pkg::SL_DEV;
      cnt_reg <= 4'h0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (stop_det) begin
      // Standby after any STOP; write launch is seen by the timer
      st_reg <= eep_pkg::SL_IDLE;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (act && scl_rise) begin
      if (ack_reg) begin
        nack_reg <= sda_reg[1];
      end else if (cnt_reg != eep_pkg::ACK_BIT) begin
        cnt_reg <= cnt_reg + 4'h1;
        // Transmit keeps its own bits; receive samples on the rise
        if (st_reg != eep_pkg::SL_RDATA) begin
          shift_reg <= {shift_reg[6:0], sda_reg[1]};
        end
      end
    end else if (act && scl_fall && st_reg == eep_pkg::SL_RDATA) begin
      if (ack_end) begin
        ack_reg <= 1'b0;
        if (!nack_reg) begin
          // Master ACKed: next byte, counter wraps at memory end
          shift_reg <= rd_byte;
          oe_reg <= ~rd_byte[7];
          addr_reg <= addr_reg + 13'h0001;
          cnt_reg <= 4'h0;
        end else begin
          // NACK: wait for the STOP in standby
          st_reg <= eep_pkg::SL_IDLE;
          oe_reg <= 1'b0;
        end
      end else if (byte_end) begin
        oe_reg <= 1'b0;  // Release for the master answer
        ack_reg <= 1'b1;
      end else begin
        shift_reg <= {shift_reg[6:0], 1'b0};
        oe_reg <= ~shift_reg[6];
      end
    end else if (byte_end) begin
      ack_reg <= 1'b1;
      unique case (st_reg)
        eep_pkg::SL_DEV: begin
          // Busy or foreign address: stay silent
          if (dev_match && !busy_reg) begin
            oe_reg <= 1'b1;
            rw_reg <= shift_reg[0];
          end else begin
            st_reg <= eep_pkg::SL_IDLE;
            ack_reg <= 1'b0;
          end
        end
        eep_pkg::SL_AHI: begin
          addr_reg[12:8] <= shift_reg[eep_pkg::AHI_USED_MSB:0];
          oe_reg <= 1'b1;
        end
        eep_pkg::SL_ALO: begin
          addr_reg[7:0] <= shift_reg;
          oe_reg <= 1'b1;
        end
        default: begin
          // Data byte: byte pointer wraps within the page
          valid_reg[widx] <= 1'b1;
          addr_reg[5:0] <= widx + 6'h01;
          oe_reg <= 1'b1;
        end
      endcase
    end else if (ack_end) begin
      ack_reg <= 1'b0;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
      unique case (st_reg)
        eep_pkg::SL_DEV: begin
          if (rw_reg == eep_pkg::RW_READ) begin
            // Send the byte the counter points at
            st_reg <= eep_pkg::SL_RDATA;
            shift_reg <= rd_byte;
            oe_reg <= ~rd_byte[7];
            addr_reg <= addr_reg + 13'h0001;
          end else begin
            st_reg <= eep_pkg::SL_AHI;
            valid_reg <= 64'h0;
          end
        end
        eep_pkg::SL_AHI: st_reg <= eep_pkg::SL_ALO;
        default: st_reg <= eep_pkg::SL_WDATA;
      endcase
    end
  end

  // ************************************************************
  // Internal write cycle
  // ************************************************************
  // Busy for the full write time; commits one buffered byte a clock
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      tmr_reg <= 32'h0;
      cidx_reg <= 7'h00;
    end else if (launch) begin
      busy_reg <= 1'b1;
      tmr_reg <= 32'h0;
      cidx_reg <= 7'h00;
    end else if (busy_reg) begin
      tmr_reg <= tmr_reg + 32'h1;
      cidx_reg <= cidx_reg + {6'h00, ~cidx_reg[6]};
      if (tmr_reg == 32'(WR_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Memory and page buffer; no reset so they map to RAM
  always_ff @(posedge ref_clk) begin
    if (buf_we) begin
      pbuf[widx] <= shift_reg;
    end
    if (commit_we) begin
      mem[{addr_reg[12:6], cidx_reg[5:0]}] <= pbuf[cidx_reg[5:0]];
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign bus.slave_sda_oe = oe_reg;
  assign write_busy = busy_reg;

endmodule : eep_slave

/* bench/eep_asserts.sv */
`timescale 1ns/1ps
// ****
// Link checker
// ****
module eep_asserts #(
  parameter int WR_CYCLES = 200
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Link and status
  input wire logic scl,
  input wire logic master_sda_oe,
  input wire logic slave_sda_oe,
  input wire logic sda,
  input wire logic write_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Busy cycles so far; a length slip shows at the fall
  int busy_cnt_reg;
  always_ff @(posedge ref_clk) begin
    busy_cnt_reg <= write_busy ? busy_cnt_reg + 1 : 0;
  end
  slave_edge_a: assert property (
    $changed(slave_sda_oe) |-> !scl) else $error("slave data moved with clock high");
  no_fight_a: assert property (
    !(master_sda_oe && slave_sda_oe)) else $error("both ends pull data");
  clk_high_a: assert property (
    $rose(scl) |-> scl[*8]) else $error("clock high too short");
  busy_stop_a: assert property (
    $rose(write_busy) |-> scl && sda) else $error("write began without stop");
  busy_quiet_a: assert property (
    write_busy |-> !slave_sda_oe) else $error("answer while busy");
  busy_hold_a: assert property (
    $rose(write_busy) |=> write_busy[*8]) else $error("write cycle cut short");
  busy_len_a: assert property (
    $fell(write_busy) |-> busy_cnt_reg == WR_CYCLES) else $error("write time wrong");
  reset_idle_a: assert property (disable iff (1'b0)
    !rstn |=> scl && !slave_sda_oe && !write_busy) else $error("not idle in reset");
endmodule : eep_asserts

/* bench/i2c_serial_eeprom_access_tb.sv */
`timescale 1ns/1ps
module i2c_serial_eeprom_access_tb;
  // ****
  // Stimulus and model state
  // ****
  localparam int WR_CYC = 200; // Short write time keeps the run brief
  logic ref_clk = 0, rstn = 0, cmd_valid = 0, cmd_read = 0, wr_valid = 0, protect = 0;
  logic [2:0] cmd_dev = 3'h5, straps = 3'h5;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00, wr_data = 8'h00, rd_data;
  logic cmd_ready, wr_ready, rd_valid, done, nack, write_busy;
  logic [7:0] mdl [0:8191]; // Reference copy of the array
  logic [31:0] seed = 32'h6B1B7453;
  int miscompares = 0, samples_checked = 0, ptr;
  eep_bus_if eep_bus_if_inst ();
  eep_slave #(.WR_CYCLES(WR_CYC)) eep_slave_inst (.ref_clk(ref_clk), .rstn(rstn),
    .bus(eep_bus_if_inst), .bus_select_pin_zero(straps[0]), .bus_select_pin_one(straps[1]),
    .bus_select_pin_two(straps[2]), .write_protect(protect), .write_busy(write_busy));
  eep_master eep_master_inst (.ref_clk(ref_clk), .rstn(rstn), .bus(eep_bus_if_inst),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack));
  eep_asserts #(.WR_CYCLES(WR_CYC)) eep_asserts_inst (.ref_clk(ref_clk), .rstn(rstn),
    .scl(eep_bus_if_inst.scl), .master_sda_oe(eep_bus_if_inst.master_sda_oe),
    .slave_sda_oe(eep_bus_if_inst.slave_sda_oe), .sda(eep_bus_if_inst.sda),
    .write_busy(write_busy));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // Queue random bytes; the model drops them when protected
  task automatic write_bytes(input logic [15:0] a, input int n, input logic wp);
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      check("wr_ready", wr_ready, 1'b1);
      wr_data = seed[7:0];
      wr_valid = 1;
      @(negedge ref_clk);
      wr_valid = 0;
      if (!wp) mdl[{a[12:6], 6'(a[5:0] + i)}] = wr_data;
      @(negedge ref_clk);
    end
  endtask : write_bytes
  // One command; read bytes are compared as they arrive
  task automatic run_cmd(input logic rd, input logic [2:0] dev, input logic [15:0] a,
      input logic [7:0] n, input logic exp_nack);
    int i;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1;
    @(negedge ref_clk);
    cmd_valid = 0;
    check("cmd_ready", cmd_ready, 1'b0);
    ptr = a[12:0];
    for (i = 0; i < 20000 && done !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1) begin
        check("rd_data", rd_data, mdl[ptr]);
        ptr = (ptr + 1) % 8192;
      end
    end
    if (i == 20000) begin
      miscompares++;
      complete_run();
    end
    check("nack", nack, exp_nack);
    check("cmd_ready", cmd_ready, 1'b1);
  endtask : run_cmd
  // Busy shows a few cycles after stop; bounded wait for its end
  task automatic wait_idle();
    int i;
    repeat (10) @(negedge ref_clk);
    for (i = 0; i < 1000 && write_busy !== 1'b0; i++) @(negedge ref_clk);
    check("write_busy", write_busy, 1'b0);
    if (write_busy !== 1'b0) complete_run();
  endtask : wait_idle
  // ****
  // Clock and main sequence
  // ****
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rstn = 1;
    write_bytes(16'hE17C, 8, 0);
    check("wr_ready", wr_ready, 1'b0); // Full FIFO refuses
    run_cmd(0, 3'h5, 16'hE17C, 8'h08, 0);
    run_cmd(1, 3'h5, 16'h0140, 8'h04, 1);
    wait_idle();
    run_cmd(1, 3'h5, 16'h0140, 8'h04, 0);
    run_cmd(1, 3'h5, 16'h017C, 8'h04, 0);
    write_bytes(16'h1FFF, 1, 0);
    run_cmd(0, 3'h5, 16'h1FFF, 8'h01, 0);
    wait_idle();
    write_bytes(16'h0000, 1, 0);
    run_cmd(0, 3'h5, 16'h0000, 8'h01, 0);
    wait_idle();
    protect = 1;
    write_bytes(16'h1FFF, 1, 1);
    run_cmd(0, 3'h5, 16'h1FFF, 8'h01, 0);
    repeat (10) @(negedge ref_clk);
    check("write_busy", write_busy, 1'b0);
    protect = 0;
    run_cmd(1, 3'h5, 16'h1FFF, 8'h02, 0);
    for (int d = 0; d < 8; d++) begin
      straps = 3'(d);
      run_cmd(1, 3'(d), 16'h0000, 8'h01, 0);
      run_cmd(1, 3'(d) ^ 3'h1, 16'h0000, 8'h01, 1);
    end
    complete_run();
  end
endmodule : i2c_serial_eeprom_access_tb
